/* File: rtl/adcti_pkg.sv */
// shared constants and types for the converter control block
package adcti_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS     = 8'h00;
  localparam logic [7:0] OFF_CTL1       = 8'h04; // converter_control_one
  localparam logic [7:0] OFF_CTL2       = 8'h08; // converter_control_two
  localparam logic [7:0] OFF_WD_HIGH    = 8'h24; // watchdog_high_threshold
  localparam logic [7:0] OFF_WD_LOW     = 8'h28; // watchdog_low_threshold
  localparam logic [7:0] OFF_SEQ        = 8'h2C; // channel sequence setup
  localparam logic [7:0] OFF_INJ_RESULT = 8'h3C; // injected result
  localparam logic [7:0] OFF_REG_RESULT = 8'h4C; // regular_result_register

  // status bit positions
  localparam int ST_WD   = 0; // watchdog_event_flag
  localparam int ST_EOC  = 1; // conversion done flag
  localparam int ST_INJECTED_GROUP_DONE_FLAG = 2; // injected_group_done_flag

  // converter_control_one bit positions (bits 9..0 implemented)
  localparam int C1_CH_LSB = 0; // watchdog_channel_number [4:0]
  localparam int C1_CONVERSION_DONE_IRQ_ENABLE  = 5;
  localparam int C1_WDIE   = 6;
  localparam int C1_INJECTED_GROUP_DONE_IRQ_ENABLE = 7;
  localparam int C1_SCAN   = 8;
  localparam int C1_SINGLE = 9;
  localparam int C1_W      = 10;

  // converter_control_two bit positions
  localparam int C2_REGULAR_EXTERNAL_TRIGGER_ENABLE = 20;
  localparam int C2_JSTART  = 21;
  localparam int C2_START   = 22;

  // sequence setup field positions
  localparam int SQ_FIRST = 0;
  localparam int SQ_LAST  = 4;
  localparam int SQ_INJ   = 8;

  // reset values
  localparam logic [9:0]  CTL1_RESET    = 10'h000;
  localparam logic [2:0]  CTL2_RESET    = 3'h0;
  localparam logic [15:0] WD_HIGH_RESET = 16'hFFFF;
  localparam logic [15:0] WD_LOW_RESET  = 16'h0000;
  localparam logic [11:0] SEQ_RESET     = 12'h000;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ADCTI_IDLE     = 3'b001,
    ADCTI_REGULAR  = 3'b010,
    ADCTI_INJECTED = 3'b100
  } adcti_state_type;
endpackage

/* File: rtl/adcti_wd_if.sv */
// bundle between the sequencer and the watchdog window checker
interface adcti_wd_if;
  logic [15:0] sample;   // converted value, zero extended
  logic [4:0]  channel;  // channel the sample came from
  logic [15:0] high;     // upper threshold
  logic [15:0] low;      // lower threshold
  logic        single;   // guard one channel only
  logic [4:0]  guard_ch; // guarded channel number
  logic        hit;      // sample is a watchdog event
  modport owner (output sample, channel, high, low, single, guard_ch,
                 input hit);
  modport judge (input sample, channel, high, low, single, guard_ch,
                 output hit);
endinterface

/* File: rtl/adcti_pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin
module adcti_pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic ff1; // metastable stage, read only by ff2
  logic ff2; // second stage
  logic ff3; // third stage

  // level moves only when the last two stages agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ff1   <= 1'b0;
      ff2   <= 1'b0;
      ff3   <= 1'b0;
      level <= 1'b0;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3) begin
        level <= ff3;
      end
    end
  end
endmodule

/* File: rtl/adcti_window_check.sv */
// analog watchdog window and channel scope check
module adcti_window_check (
  adcti_wd_if.judge wd
);
  wire outside; // value beyond either threshold
  wire in_scope; // channel is watched

  assign outside  = (wd.sample > wd.high) || (wd.sample < wd.low);
  // one channel by binary number, or every channel
  assign in_scope = !wd.single || (wd.channel == wd.guard_ch);
  assign wd.hit   = outside && in_scope;
endmodule

/* File: rtl/adcti_top.sv */
// converter control, trigger and interrupt logic with an axi4-lite slave
// Operation
// - single bit limits watchdog to chosen channel
// - scan converts first through last channel
// - injected done interrupt only when enabled
// - watchdog interrupt only when enabled
// - watchdog interrupt aborts a running scan
// - conversion done interrupt for either group
// - channel field selects channel by number
// - regular soft start cleared when conversion starts
// - injected soft start cleared by hardware or software
// - external trigger starts regular only when enabled
// - conversion done set, cleared by zero or read
// - injected done set, cleared by zero only
// - watchdog flag set outside threshold window
//
// Register access over AXI4-Lite was left to the implementer.
module adcti_top #(
  parameter int DATA_W = 10 // converter sample width, at most 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_trigger_pin,
  output logic                   conv_start,
  output logic [4:0]             conv_channel,
  input  wire logic              conv_done,
  input  wire logic [DATA_W-1:0] conv_data,
  output logic                   irq
);
  // bus capture
  logic        aw_held;  // write address waiting
  logic        w_held;   // write data waiting
  logic [7:0]  aw_addr;  // captured write address
  logic [31:0] w_data;   // captured write data
  logic [3:0]  w_strb;   // captured byte enables
  logic [7:0]  rd_addr;  // address of the answer in flight

  // software visible state
  localparam int C1_W_T = adcti_pkg::C1_W; // implemented control one bits
  logic [C1_W_T-1:0] ctl1;     // converter_control_one bits 9..0
  logic [2:0]        ctl2;     // control two bits 22..20
  logic              eoc;      // conversion done flag
  logic              injected_group_done_flag;     // injected_group_done_flag
  logic              wd_flag;  // watchdog_event_flag
  logic [15:0]       wd_high;  // watchdog_high_threshold
  logic [15:0]       wd_low;   // watchdog_low_threshold
  logic [11:0]       seq_cfg;  // first, last and injected channel
  logic [15:0]       reg_result; // regular result
  logic [15:0]       inj_result; // injected result

  // sequencer
  adcti_pkg::adcti_state_type state;
  adcti_pkg::adcti_state_type next_state;
  logic trig_prev; // filtered trigger one cycle back
  wire  trig_level; // filtered trigger level

  // all checks below run on sys_clk and rest during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // merge written bytes over an old word
  function automatic logic [31:0] adcti_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (new_v & m) | (old_v & ~m);
  endfunction

  // bus handshakes and decode
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire do_wr = aw_held && w_held && !s_axi_bvalid;
  wire next_aw_held = (aw_held || aw_hs) && !do_wr;
  wire next_w_held  = (w_held || w_hs) && !do_wr;
  wire next_bvalid  = do_wr || (s_axi_bvalid && !s_axi_bready);
  wire next_rvalid  = ar_hs || (s_axi_rvalid && !s_axi_rready);

  wire wr_status = do_wr && (aw_addr == adcti_pkg::OFF_STATUS);
  wire wr_ctl1   = do_wr && (aw_addr == adcti_pkg::OFF_CTL1);
  wire wr_ctl2   = do_wr && (aw_addr == adcti_pkg::OFF_CTL2);
  wire wr_high   = do_wr && (aw_addr == adcti_pkg::OFF_WD_HIGH);
  wire wr_low    = do_wr && (aw_addr == adcti_pkg::OFF_WD_LOW);
  wire wr_seq    = do_wr && (aw_addr == adcti_pkg::OFF_SEQ);
  wire wr_hit    = wr_status || wr_ctl1 || wr_ctl2 || wr_high ||
                   wr_low || wr_seq;

  // written images of each register
  wire [31:0] ctl1_w = adcti_merge({22'h0, ctl1}, w_data, w_strb);
  wire [31:0] ctl2_w = adcti_merge({9'h0, ctl2, 20'h0}, w_data, w_strb);
  wire [31:0] high_w = adcti_merge({16'h0, wd_high}, w_data, w_strb);
  wire [31:0] low_w  = adcti_merge({16'h0, wd_low}, w_data, w_strb);
  wire [31:0] seq_w  = adcti_merge({20'h0, seq_cfg}, w_data, w_strb);
  // control one as it will stand after this edge
  wire [C1_W_T-1:0] next_ctl1 = wr_ctl1 ? ctl1_w[C1_W_T-1:0] : ctl1;
  // a status bit clears only where its lane is enabled and a zero written
  wire [31:0] st_w   = adcti_merge(32'hFFFF_FFFF, w_data, w_strb);

  // control field views
  wire       scan_en   = ctl1[adcti_pkg::C1_SCAN];
  wire       eoc_ie    = ctl1[adcti_pkg::C1_CONVERSION_DONE_IRQ_ENABLE];
  wire       injected_group_done_flag_ie   = ctl1[adcti_pkg::C1_INJECTED_GROUP_DONE_IRQ_ENABLE];
  wire       wd_ie     = ctl1[adcti_pkg::C1_WDIE];
  wire       reg_soft_start = ctl2[adcti_pkg::C2_START - 20];
  wire       inj_soft_start = ctl2[adcti_pkg::C2_JSTART - 20];
  wire       ext_trig_en    = ctl2[adcti_pkg::C2_REGULAR_EXTERNAL_TRIGGER_ENABLE - 20];
  wire [3:0] reg_first = seq_cfg[adcti_pkg::SQ_FIRST +: 4];
  wire [3:0] reg_last  = seq_cfg[adcti_pkg::SQ_LAST +: 4];
  wire [3:0] inj_ch    = seq_cfg[adcti_pkg::SQ_INJ +: 4];

  // watchdog window checker
  adcti_wd_if wd_bus ();
  assign wd_bus.sample   = {{(16-DATA_W){1'b0}}, conv_data};
  assign wd_bus.channel  = conv_channel;
  assign wd_bus.high     = wd_high;
  assign wd_bus.low      = wd_low;
  assign wd_bus.single   = ctl1[adcti_pkg::C1_SINGLE];
  assign wd_bus.guard_ch = ctl1[adcti_pkg::C1_CH_LSB +: 5];
  adcti_window_check u_window (
    .wd (wd_bus.judge)
  );

  // external trigger pin enters through the filter
  adcti_pin_sync u_trig_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (ext_trigger_pin),
    .level   (trig_level)
  );

  // sequencer decisions
  wire idle      = (state == adcti_pkg::ADCTI_IDLE);
  wire in_reg    = (state == adcti_pkg::ADCTI_REGULAR);
  wire in_inj    = (state == adcti_pkg::ADCTI_INJECTED);
  wire trig_rise = trig_level && !trig_prev;
  // injected request wins a tie; a trigger edge seen while busy is lost
  wire start_inj = idle && inj_soft_start;
  wire start_reg = idle && !inj_soft_start &&
                   (reg_soft_start || (ext_trig_en && trig_rise));
  wire wd_hit    = (in_reg || in_inj) && conv_done && wd_bus.hit;
  // watchdog interrupt in scan stops the remaining channels
  wire abort     = in_reg && conv_done && scan_en && wd_hit && wd_ie;
  wire at_last   = (conv_channel[3:0] == reg_last);
  wire scan_step = in_reg && conv_done && scan_en && !abort &&
                   !at_last;
  wire reg_end   = in_reg && conv_done && !abort && !scan_step;
  wire inj_end   = in_inj && conv_done;
  wire rd_result = ar_hs && (s_axi_araddr == adcti_pkg::OFF_REG_RESULT);

  // flag updates, a hardware set wins over any clear in the same cycle
  wire next_eoc  = reg_end || inj_end ||
                   (eoc && !(wr_status && !st_w[adcti_pkg::ST_EOC]) &&
                    !rd_result);
  wire next_injected_group_done_flag = inj_end ||
                   (injected_group_done_flag && !(wr_status && !st_w[adcti_pkg::ST_INJECTED_GROUP_DONE_FLAG]));
  wire next_wd   = wd_hit ||
                   (wd_flag && !(wr_status && !st_w[adcti_pkg::ST_WD]));
  // enables taken as they will stand, so irq never lags a mask write
  wire next_irq  = (next_eoc && next_ctl1[adcti_pkg::C1_CONVERSION_DONE_IRQ_ENABLE]) ||
                   (next_injected_group_done_flag && next_ctl1[adcti_pkg::C1_INJECTED_GROUP_DONE_IRQ_ENABLE]) ||
                   (next_wd && next_ctl1[adcti_pkg::C1_WDIE]);

  // read decode
  wire [31:0] rd_word =
    (s_axi_araddr == adcti_pkg::OFF_STATUS) ? {29'h0, injected_group_done_flag, eoc, wd_flag} :
    (s_axi_araddr == adcti_pkg::OFF_CTL1)   ? {22'h0, ctl1} :
    (s_axi_araddr == adcti_pkg::OFF_CTL2)   ? {9'h0, ctl2, 20'h0} :
    (s_axi_araddr == adcti_pkg::OFF_WD_HIGH) ? {16'h0, wd_high} :
    (s_axi_araddr == adcti_pkg::OFF_WD_LOW) ? {16'h0, wd_low} :
    (s_axi_araddr == adcti_pkg::OFF_SEQ)    ? {20'h0, seq_cfg} :
    (s_axi_araddr == adcti_pkg::OFF_INJ_RESULT) ? {16'h0, inj_result} :
    (s_axi_araddr == adcti_pkg::OFF_REG_RESULT) ? {16'h0, reg_result} :
    32'h0000_0000;
  wire rd_hit = (s_axi_araddr == adcti_pkg::OFF_STATUS) ||
                (s_axi_araddr == adcti_pkg::OFF_CTL1) ||
                (s_axi_araddr == adcti_pkg::OFF_CTL2) ||
                (s_axi_araddr == adcti_pkg::OFF_WD_HIGH) ||
                (s_axi_araddr == adcti_pkg::OFF_WD_LOW) ||
                (s_axi_araddr == adcti_pkg::OFF_SEQ) ||
                (s_axi_araddr == adcti_pkg::OFF_INJ_RESULT) ||
                (s_axi_araddr == adcti_pkg::OFF_REG_RESULT);

  // next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      adcti_pkg::ADCTI_IDLE: begin
        if (start_inj) begin
          next_state = adcti_pkg::ADCTI_INJECTED;
        end else if (start_reg) begin
          next_state = adcti_pkg::ADCTI_REGULAR;
        end
      end
      adcti_pkg::ADCTI_REGULAR: begin
        if (abort || reg_end) begin
          next_state = adcti_pkg::ADCTI_IDLE;
        end
      end
      adcti_pkg::ADCTI_INJECTED: begin
        if (inj_end) begin
          next_state = adcti_pkg::ADCTI_IDLE;
        end
      end
      default: next_state = adcti_pkg::ADCTI_IDLE;
    endcase
  end

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adcti_pkg::RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready  <= !next_w_held && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (aw_hs) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bresp <= wr_hit ? adcti_pkg::RESP_OKAY : adcti_pkg::RESP_SLVERR;
      end
    end
  end

  // read channel: one answer, one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= adcti_pkg::RESP_OKAY;
      rd_addr       <= 8'h00;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? adcti_pkg::RESP_OKAY : adcti_pkg::RESP_SLVERR;
        rd_addr     <= s_axi_araddr;
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl1    <= adcti_pkg::CTL1_RESET;
      wd_high <= adcti_pkg::WD_HIGH_RESET;
      wd_low  <= adcti_pkg::WD_LOW_RESET;
      seq_cfg <= adcti_pkg::SEQ_RESET;
    end else begin
      if (wr_ctl1) begin
        ctl1 <= ctl1_w[C1_W_T-1:0];
      end
      if (wr_high) begin
        wd_high <= high_w[15:0];
      end
      if (wr_low) begin
        wd_low <= low_w[15:0];
      end
      if (wr_seq) begin
        seq_cfg <= seq_w[11:0];
      end
    end
  end

  // start bits: software sets or clears, hardware clears on start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl2 <= adcti_pkg::CTL2_RESET;
    end else if (wr_ctl2) begin
      ctl2 <= ctl2_w[adcti_pkg::C2_START:adcti_pkg::C2_REGULAR_EXTERNAL_TRIGGER_ENABLE];
    end else begin
      if (start_reg) begin
        ctl2[adcti_pkg::C2_START - 20] <= 1'b0;
      end
      if (start_inj) begin
        ctl2[adcti_pkg::C2_JSTART - 20] <= 1'b0;
      end
    end
  end

  // sequencer, converter strobe and results
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state        <= adcti_pkg::ADCTI_IDLE;
      trig_prev    <= 1'b0;
      conv_start   <= 1'b0;
      conv_channel <= 5'h00;
      reg_result   <= adcti_pkg::RESULT_RESET;
      inj_result   <= adcti_pkg::RESULT_RESET;
    end else begin
      state      <= next_state;
      trig_prev  <= trig_level;
      conv_start <= start_inj || start_reg || scan_step;
      if (start_inj) begin
        conv_channel <= {1'b0, inj_ch};
      end else if (start_reg) begin
        conv_channel <= {1'b0, reg_first};
      end else if (scan_step) begin
        conv_channel <= {1'b0, conv_channel[3:0] + 4'h1};
      end
      if (in_reg && conv_done) begin
        reg_result <= wd_bus.sample;
      end
      if (inj_end) begin
        inj_result <= wd_bus.sample;
      end
    end
  end

  // status flags and the interrupt line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eoc     <= 1'b0;
      injected_group_done_flag    <= 1'b0;
      wd_flag <= 1'b0;
      irq     <= 1'b0;
    end else begin
      eoc     <= next_eoc;
      injected_group_done_flag    <= next_injected_group_done_flag;
      wd_flag <= next_wd;
      irq     <= next_irq;
    end
  end

  // checks
  sequence s_last_done;
    in_reg && conv_done && !abort && !scan_step;
  endsequence
  sequence s_done_seen;
    eoc && !conv_start ##1 !conv_start;
  endsequence

  property p_soft_start;
    idle && reg_soft_start && !inj_soft_start && !wr_ctl2 |=>
      !reg_soft_start && conv_start && in_reg;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("regular soft start not taken and cleared");

  property p_inj_start;
    idle && inj_soft_start && !wr_ctl2 |=>
      !inj_soft_start && in_inj && conv_channel == {1'b0, inj_ch};
  endproperty
  a_inj_start: assert property (p_inj_start)
    else $error("injected soft start not taken and cleared");

  property p_ext_gate;
    idle && !ext_trig_en && !reg_soft_start && !inj_soft_start |=>
      !conv_start;
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("conversion started without a request");

  property p_scan_step;
    scan_step |=> conv_start &&
      conv_channel[3:0] == 4'($past(conv_channel[3:0]) + 4'h1);
  endproperty
  a_scan_step: assert property (p_scan_step)
    else $error("scan did not move to the next channel");

  property p_scan_abort;
    in_reg && conv_done && scan_en && wd_bus.hit && wd_ie |=>
      (idle && !conv_start && !eoc) [*2];
  endproperty
  a_scan_abort: assert property (p_scan_abort)
    else $error("scan continued after watchdog interrupt");

  property p_eoc_set;
    s_last_done |=> eoc ##0 (irq || !eoc_ie);
  endproperty
  a_eoc_set: assert property (p_eoc_set)
    else $error("group end did not set done flag");

  property p_irq_cause;
    irq |-> (eoc && eoc_ie) || (injected_group_done_flag && injected_group_done_flag_ie) || (wd_flag && wd_ie);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without an enabled flag");

  property p_irq_wd;
    wd_flag && wd_ie |-> irq;
  endproperty
  a_irq_wd: assert property (p_irq_wd)
    else $error("enabled watchdog flag gave no interrupt");

  property p_injected_group_done_flag_set;
    inj_end |=> injected_group_done_flag && eoc && (irq || !injected_group_done_flag_ie);
  endproperty
  a_injected_group_done_flag_set: assert property (p_injected_group_done_flag_set)
    else $error("injected end did not set its flags");

  property p_injected_group_done_flag_hold;
    injected_group_done_flag && !wr_status |=> injected_group_done_flag;
  endproperty
  a_injected_group_done_flag_hold: assert property (p_injected_group_done_flag_hold)
    else $error("injected done flag dropped by itself");

  property p_wd_set;
    wd_hit |=> wd_flag;
  endproperty
  a_wd_set: assert property (p_wd_set)
    else $error("watchdog event not flagged");

  property p_read_clear;
    rd_result && !reg_end && !inj_end |=> !eoc;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("result read did not clear done flag");

  property p_ctl2_zero;
    s_axi_rvalid && rd_addr == adcti_pkg::OFF_CTL2 |->
      s_axi_rdata[31:23] == 9'h000;
  endproperty
  a_ctl2_zero: assert property (p_ctl2_zero)
    else $error("reserved control bits read nonzero");

  property p_done_hold;
    s_done_seen |-> eoc || !idle || $past(wr_status) || $past(rd_result);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done flag cleared without cause");
endmodule

/* File: tb/adc_control_trigger_irq_bench.sv */
// self-checking bench for the converter control block
module adc_control_trigger_irq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, irq;
  logic        ext_trigger_pin, conv_start, conv_done;
  logic [4:0]  conv_channel, ch; // ch: channel seen at start
  logic [9:0]  conv_data;
  logic [31:0] rv;               // last read word
  logic [1:0]  rr;               // last bus answer
  logic [3:0]  f, j, g;          // first, injected, guarded channel
  int          errors, n_tests;

  adcti_top #(.DATA_W(10)) DUT (.sys_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_trigger_pin, .conv_start, .conv_channel, .conv_done,
    .conv_data, .irq);

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // expected status word from the three flags
  function automatic logic [31:0] st(input logic jd, d, w);
    return {29'h0, jd, d, w};
  endfunction

  // bus write; waits for the answer, no fixed latency assumed
  // bready and rready stay high between transfers, never toggled twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask

  // bus read into rv and rr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    rd(a);
    chk(n, rv, e);
  endtask

  // converter stand-in: wait for a start, answer with sample v
  task automatic conv(input logic [9:0] v, input logic e);
    int i;
    i = 0;
    while (!conv_start && i < 30) begin
      @(posedge sys_clk);
      i++;
    end
    chk("conv_start", conv_start, e);
    ch = conv_channel;
    if (conv_start) begin
      conv_data <= v;
      conv_done <= 1'b1;
      @(posedge sys_clk);
      conv_done <= 1'b0;
      conv_data <= 10'($urandom);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict;
  end

  initial begin
    void'($urandom(87702));
    {rst, s_axi_wstrb} = 5'h1F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, conv_data} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, ext_trigger_pin, conv_done} = '0;
    {errors, n_tests} = '0;
    f = 4'($urandom);
    j = 4'($urandom);
    g = f + 4'h5;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc("ctl1", 8'h04, 32'h0);
    rc("ctl2", 8'h08, 32'h0);
    rc("wd_high", 8'h24, 32'h0000_FFFF);
    wr(8'h2C, {20'h0_0000, j, f + 4'h2, f});
    chk("bresp", rr, 0);
    wr(8'h04, 32'h0000_00A0);
    wr(8'h08, 32'h0040_0000);
    conv(10'h155, 1'b1);
    chk("channel", ch, {1'b0, f});
    rc("ctl2", 8'h08, 32'h0);
    rc("status", 8'h00, 32'h2);
    chk("irq", irq, 1);
    rc("result", 8'h4C, 32'h155);
    rc("status", 8'h00, 32'h0);
    @(posedge sys_clk);
    chk("irq", irq, 0);
    $display("test regular done");
    wr(8'h08, 32'h0020_0000);
    conv(10'h0AA, 1'b1);
    chk("channel", ch, {1'b0, j});
    rc("ctl2", 8'h08, 32'h0);
    rc("status", 8'h00, 32'h6);
    chk("irq", irq, 1);
    wr(8'h00, 32'hFFFF_FFFF);
    rc("status", 8'h00, 32'h6);
    wr(8'h00, 32'h0000_0003);
    rc("status", 8'h00, 32'h2);
    wr(8'h00, 32'h0);
    @(posedge sys_clk);
    chk("irq", irq, 0);
    $display("test injected done");
    wr(8'h28, 32'h100);
    wr(8'h24, 32'h200);
    wr(8'h04, 32'h0000_0240 | g);
    wr(8'h08, 32'h0040_0000);
    conv(10'h3FF, 1'b1);
    rc("status", 8'h00, 32'h2);
    chk("irq", irq, 0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0000_0200 | f);
    wr(8'h08, 32'h0040_0000);
    conv(10'h050, 1'b1);
    rc("status", 8'h00, 32'h3);
    chk("irq", irq, 0);
    wr(8'h00, 32'h0);
    $display("test watchdog done");
    wr(8'h04, 32'h0000_0140);
    wr(8'h08, 32'h0040_0000);
    conv(10'h180, 1'b1);
    chk("channel", ch, {1'b0, f});
    conv(10'h201, 1'b1);
    chk("channel", ch, {1'b0, f + 4'h1});
    conv(10'h180, 1'b0);
    rd(8'h00);
    chk("wd flag", rv[0], 1);
    chk("irq", irq, 1);
    wr(8'h00, 32'h0);
    rd(8'h40);
    chk("resp", rr, 2);
    wr(8'h40, 32'h1);
    chk("bresp", rr, 2);
    wr(8'h04, 32'h0000_0100);
    wr(8'h08, 32'h0040_0000);
    conv(10'h150, 1'b1);
    chk("channel", ch, {1'b0, f});
    conv(10'h160, 1'b1);
    chk("channel", ch, {1'b0, f + 4'h1});
    conv(10'h170, 1'b1);
    chk("channel", ch, {1'b0, f + 4'h2});
    conv(10'h0, 1'b0);
    rc("status", 8'h00, st(1'b0, 1'b1, 1'b0));
    wr(8'h00, 32'h0);
    $display("test scan done");
    wr(8'h04, 32'h0);
    wr(8'h08, 32'hFF90_0000);
    rc("ctl2", 8'h08, 32'h0010_0000);
    ext_trigger_pin <= 1'b1;
    conv(10'h123, 1'b1);
    ext_trigger_pin <= 1'b0;
    wr(8'h08, 32'h0);
    repeat (8) @(posedge sys_clk);
    ext_trigger_pin <= 1'b1;
    conv(10'h0, 1'b0);
    $display("test trigger done");
    print_verdict;
  end
endmodule
